// ==== src/xfer_pkg.sv ====
// shared encodings and sizes for the pipelined transfer bus
package xfer_pkg;
   localparam int ADDR_W     = 32;
   localparam int DATA_W     = 32;
   localparam int FIFO_DEPTH = 8;
   localparam int MEM_AW     = 4;
   localparam int MEM_WORDS  = 16;
   localparam int CNT_W      = 5;
   localparam int WAIT_W     = 2;
   // transfer types
   localparam logic [1:0] TR_IDLE   = 2'h0;
   localparam logic [1:0] TR_BUSY   = 2'h1;
   localparam logic [1:0] TR_NONSEQ = 2'h2;
   localparam logic [1:0] TR_SEQ    = 2'h3;
   // responses
   localparam logic [1:0] RSP_OKAY  = 2'h0;
   localparam logic [1:0] RSP_ERROR = 2'h1;
   localparam logic [1:0] RSP_RETRY = 2'h2;
   localparam logic [1:0] RSP_SPLIT = 2'h3;
   // burst kinds
   localparam logic [2:0] BU_SINGLE = 3'h0;
   localparam logic [2:0] BU_INCR   = 3'h1;
   localparam logic [2:0] BU_WRAP4  = 3'h2;
   localparam logic [2:0] BU_INCR4  = 3'h3;
   localparam logic [2:0] BU_WRAP8  = 3'h4;
   localparam logic [2:0] BU_INCR8  = 3'h5;
   localparam logic [2:0] BU_WRAP16 = 3'h6;
   localparam logic [2:0] BU_INCR16 = 3'h7;
   localparam logic [CNT_W-1:0] BEATS_1  = 5'h01;
   localparam logic [CNT_W-1:0] BEATS_4  = 5'h04;
   localparam logic [CNT_W-1:0] BEATS_8  = 5'h08;
   localparam logic [CNT_W-1:0] BEATS_16 = 5'h10;
   // sizes
   localparam logic [2:0] SZ_BYTE = 3'h0;
   localparam logic [2:0] SZ_HALF = 3'h1;
endpackage

// ==== src/bus_if.sv ====
// bus signals between the master end and the slave end
`timescale 1ns/1ps
interface bus_if;
   logic                          hreq;
   logic                          hgrant;
   logic [xfer_pkg::ADDR_W-1:0]   haddr;
   logic [1:0]                    htrans;
   logic                          hwrite;
   logic [2:0]                    hsize;
   logic [2:0]                    hburst;
   logic [xfer_pkg::DATA_W-1:0]   hwdata;
   logic [xfer_pkg::DATA_W-1:0]   hrdata;
   logic                          hready;
   logic [1:0]                    hresp;

   modport master (
      output hreq,
      output hgrant,
      output haddr,
      output htrans,
      output hwrite,
      output hsize,
      output hburst,
      output hwdata,
      input  hrdata,
      input  hready,
      input  hresp
   );
   modport slave (
      input  haddr,
      input  htrans,
      input  hwrite,
      input  hsize,
      input  hburst,
      input  hwdata,
      output hrdata,
      output hready,
      output hresp
   );
endinterface

// ==== src/beat_fifo.sv ====
// small synchronous fifo holding write beats
`timescale 1ns/1ps
module beat_fifo #(
   parameter int W = 32,
   parameter int D = 8
) (
   input  wire logic          sys_clk,
   input  wire logic          srst,
   input  wire logic          in_valid,
   output logic               in_ready,
   input  wire logic [W-1:0]  in_data,
   output logic               out_valid,
   input  wire logic          out_ready,
   output logic [W-1:0]       out_data
);
   localparam int PW = $clog2(D);
   logic [W-1:0]  mem_ff [D];
   logic [PW-1:0] wp_ff;
   logic [PW-1:0] nxt_wp;
   logic [PW-1:0] rp_ff;
   logic [PW-1:0] nxt_rp;
   logic [PW:0]   cnt_ff;
   logic [PW:0]   nxt_cnt;
   logic          push;
   logic          pop;

   // full and empty straight from the count
   assign in_ready  = (cnt_ff != PW'(0) + (PW+1)'(D));
   assign out_valid = (cnt_ff != '0);
   assign out_data  = mem_ff[rp_ff];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb
   begin
      nxt_wp  = push ? PW'(wp_ff + 1'b1) : wp_ff;
      nxt_rp  = pop ? PW'(rp_ff + 1'b1) : rp_ff;
      nxt_cnt = cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         wp_ff  <= '0;
         rp_ff  <= '0;
         cnt_ff <= '0;
      end
      else
      begin
         wp_ff  <= nxt_wp;
         rp_ff  <= nxt_rp;
         cnt_ff <= nxt_cnt;
      end
   end

   // storage carries no reset, only the pointers matter
   always_ff @(posedge sys_clk)
   begin
      if (push)
         mem_ff[wp_ff] <= in_data;
   end
endmodule // beat_fifo

// ==== src/bus_master.sv ====
// master end: arbiter, address pipeline, burst engine
// How it works
// - arbiter routes one master to slaves
// - decoder steers the chosen slave answer back
// - request first, start only when granted
// - drive address, direction, width and burst
// - address phase is one cycle only
// - slave stretches data phase with ready low
// - okay with ready high means done
// - error response means transfer failed
// - retry or split makes master try again
// - broken burst rebuilt after re-arbitration
// - drive after edge, answer third edge
// - next address overlaps current data phase
// - write data held through wait states
// - read data valid only when completing
// - waits stretch the next address phase
// - idle type: ignored, zero-wait okay
// - busy type pauses inside a burst
// - nonseq starts a burst or single
// - seq adds size to prior address
// - wrapping bursts wrap at size times beats
`timescale 1ns/1ps
module bus_master (
   input  wire logic                          sys_clk,
   input  wire logic                          srst,
   bus_if.master                              bus,
   input  wire logic                          cmd_valid,
   output logic                               cmd_ready,
   input  wire logic [xfer_pkg::ADDR_W-1:0]   cmd_addr,
   input  wire logic                          cmd_write,
   input  wire logic [2:0]                    cmd_size,
   input  wire logic [2:0]                    cmd_burst,
   input  wire logic [xfer_pkg::CNT_W-1:0]    cmd_beats,
   input  wire logic                          arb_hold,
   input  wire logic                          wr_valid,
   output logic                               wr_ready,
   input  wire logic [xfer_pkg::DATA_W-1:0]   wr_data,
   output logic                               rd_valid,
   output logic [xfer_pkg::DATA_W-1:0]        rd_data,
   output logic                               done,
   output logic                               done_err
);
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_RUN   = 2'b01,
      ST_DRAIN = 2'b10
   } mst_state_t;

   localparam int AW = xfer_pkg::ADDR_W;
   localparam int DW = xfer_pkg::DATA_W;
   localparam int CW = xfer_pkg::CNT_W;

   mst_state_t     st_ff, nxt_st;
   logic           grant_ff, nxt_grant;
   logic [AW-1:0]  a_addr_ff, nxt_a_addr;
   logic [1:0]     a_trans_ff, nxt_a_trans;
   logic [CW-1:0]  a_cnt_ff, nxt_a_cnt;
   logic           write_ff, nxt_write;
   logic [2:0]     size_ff, nxt_size;
   logic [2:0]     burst_ff, nxt_burst;
   logic           wrap_ff, nxt_wrap;
   logic [CW-1:0]  len_ff, nxt_len;
   logic           restart_ff, nxt_restart;
   logic           rebuilt_ff, nxt_rebuilt;
   logic           replay_ff, nxt_replay;
   logic           d_act_ff, nxt_d_act;
   logic [AW-1:0]  d_addr_ff, nxt_d_addr;
   logic [DW-1:0]  wdata_ff, nxt_wdata;
   logic           rd_valid_ff, nxt_rd_valid;
   logic [DW-1:0]  rd_data_ff, nxt_rd_data;
   logic           done_ff, nxt_done;
   logic           err_ff, nxt_err;
   logic           f_valid;
   logic           f_pop;
   logic [DW-1:0]  f_data;
   logic           a_real;
   logic           bad_rsp;
   logic [AW-1:0]  step_addr;
   logic [CW-1:0]  cnt_after;

   // write beats wait here; an empty fifo stalls with idle cycles before a nonseq beat, busy cycles before a seq beat
   beat_fifo #(.W(DW), .D(xfer_pkg::FIFO_DEPTH)) u_wfifo (
      .sys_clk   (sys_clk),
      .srst      (srst),
      .in_valid  (wr_valid),
      .in_ready  (wr_ready),
      .in_data   (wr_data),
      .out_valid (f_valid),
      .out_ready (f_pop),
      .out_data  (f_data)
   );

   // next beat address, wrapping at size times beats
   function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a,
                                               input logic [2:0] sz,
                                               input logic wr,
                                               input logic [CW-1:0] n);
      logic [AW-1:0] inc;
      logic [AW-1:0] msk;
      inc = a + (AW'(1) << sz);
      msk = (AW'(n) << sz) - AW'(1);
      next_addr = wr ? ((a & ~msk) | (inc & msk)) : inc;
   endfunction

   // beat count implied by the burst kind
   function automatic logic [CW-1:0] beats_of(input logic [2:0] b,
                                              input logic [CW-1:0] n);
      case (b)
         xfer_pkg::BU_SINGLE: beats_of = xfer_pkg::BEATS_1;
         xfer_pkg::BU_INCR:   beats_of = (n == '0) ? xfer_pkg::BEATS_1 : n;
         xfer_pkg::BU_WRAP4,
         xfer_pkg::BU_INCR4:  beats_of = xfer_pkg::BEATS_4;
         xfer_pkg::BU_WRAP8,
         xfer_pkg::BU_INCR8:  beats_of = xfer_pkg::BEATS_8;
         default:             beats_of = xfer_pkg::BEATS_16;
      endcase
   endfunction

   // single master: grant follows request unless arb_hold, moves only at ready high
   assign bus.hreq   = (st_ff != ST_IDLE) & (a_cnt_ff != '0);
   assign bus.hgrant = grant_ff;
   assign bus.haddr  = a_addr_ff;
   assign bus.htrans = a_trans_ff;
   assign bus.hwrite = write_ff;
   assign bus.hsize  = size_ff;
   assign bus.hburst = rebuilt_ff ? xfer_pkg::BU_INCR : burst_ff;
   assign bus.hwdata = wdata_ff;
   assign cmd_ready  = (st_ff == ST_IDLE);
   assign rd_valid   = rd_valid_ff;
   assign rd_data    = rd_data_ff;
   assign done       = done_ff;
   assign done_err   = err_ff;

   assign a_real    = a_trans_ff[1];
   assign bad_rsp   = (bus.hresp != xfer_pkg::RSP_OKAY);
   assign step_addr = next_addr(a_addr_ff, size_ff, wrap_ff, len_ff);
   assign cnt_after = a_cnt_ff - CW'(a_real);
   assign f_pop     = bus.hready & a_real & write_ff & ~replay_ff;

   // pipeline: address phase advances only on ready high
   always_comb
   begin
      nxt_st       = st_ff;
      nxt_grant    = grant_ff;
      nxt_a_addr   = a_addr_ff;
      nxt_a_trans  = a_trans_ff;
      nxt_a_cnt    = a_cnt_ff;
      nxt_write    = write_ff;
      nxt_size     = size_ff;
      nxt_burst    = burst_ff;
      nxt_wrap     = wrap_ff;
      nxt_len      = len_ff;
      nxt_restart  = restart_ff;
      nxt_rebuilt  = rebuilt_ff;
      nxt_replay   = replay_ff;
      nxt_d_act    = d_act_ff;
      nxt_d_addr   = d_addr_ff;
      nxt_wdata    = wdata_ff;
      nxt_rd_valid = 1'b0;
      nxt_rd_data  = rd_data_ff;
      nxt_done     = 1'b0;
      nxt_err      = 1'b0;

      if (bus.hready)
         nxt_grant = bus.hreq & ~arb_hold;

      if (st_ff == ST_IDLE && cmd_valid)
      begin
         nxt_st      = ST_RUN;
         nxt_a_addr  = cmd_addr;
         nxt_write   = cmd_write;
         nxt_size    = cmd_size;
         nxt_burst   = cmd_burst;
         nxt_len     = beats_of(cmd_burst, cmd_beats);
         nxt_a_cnt   = beats_of(cmd_burst, cmd_beats);
         nxt_wrap    = (cmd_burst != xfer_pkg::BU_SINGLE) & ~cmd_burst[0];
         nxt_restart = 1'b1;
         nxt_rebuilt = 1'b0;
         nxt_replay  = 1'b0;
      end
      else if (d_act_ff && !bus.hready && bad_rsp)
      begin
         // first response cycle: cancel the queued address, rewind on retry or split
         nxt_a_trans = xfer_pkg::TR_IDLE;
         if (bus.hresp == xfer_pkg::RSP_ERROR)
            nxt_a_cnt = '0;
         else
         begin
            nxt_a_addr  = d_addr_ff;
            nxt_a_cnt   = a_cnt_ff + CW'(1);
            nxt_restart = 1'b1;
            nxt_rebuilt = 1'b1;
            nxt_replay  = write_ff;
            nxt_st      = ST_RUN;
         end
      end
      else if (bus.hready)
      begin
         // data phase ends at this edge; address phase moves into it
         if (d_act_ff && !bad_rsp && !write_ff)
         begin
            nxt_rd_valid = 1'b1;
            nxt_rd_data  = bus.hrdata;
         end
         if (d_act_ff && bus.hresp == xfer_pkg::RSP_ERROR)
         begin
            nxt_err = 1'b1;
            nxt_st  = ST_IDLE;
         end
         else if (st_ff == ST_DRAIN && d_act_ff && !bad_rsp)
         begin
            nxt_done = 1'b1;
            nxt_st   = ST_IDLE;
         end
         nxt_d_act  = a_real;
         nxt_d_addr = a_addr_ff;
         if (a_real && write_ff && !replay_ff)
            nxt_wdata = f_data;
         if (a_real)
         begin
            nxt_replay = 1'b0;
            nxt_a_addr = (cnt_after == '0) ? a_addr_ff : step_addr;
         end
         nxt_a_cnt = cnt_after;
         if (st_ff == ST_RUN && cnt_after == '0 && !nxt_err)      // error ends it outright
            nxt_st = ST_DRAIN;

         // choose what the next address phase carries
         if (st_ff != ST_RUN || cnt_after == '0)
            nxt_a_trans = xfer_pkg::TR_IDLE;
         else if (!grant_ff)
         begin
            nxt_a_trans = xfer_pkg::TR_IDLE;
            if (!restart_ff)
               nxt_rebuilt = 1'b1;
            nxt_restart = 1'b1;
         end
         else if (write_ff && !nxt_replay && !(f_valid && !f_pop))
            nxt_a_trans = restart_ff ? xfer_pkg::TR_IDLE
                                     : xfer_pkg::TR_BUSY;
         else if (restart_ff)
         begin
            nxt_a_trans = xfer_pkg::TR_NONSEQ;
            nxt_restart = 1'b0;
         end
         else
            nxt_a_trans = xfer_pkg::TR_SEQ;
      end
      // with ready low and an okay response every bus output stays put
   end

   // registers only; ready low with an okay response freezes the address phase
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         st_ff       <= ST_IDLE;
         grant_ff    <= 1'b0;
         a_addr_ff   <= '0;
         a_trans_ff  <= xfer_pkg::TR_IDLE;
         a_cnt_ff    <= '0;
         write_ff    <= 1'b0;
         size_ff     <= xfer_pkg::SZ_BYTE;
         burst_ff    <= xfer_pkg::BU_SINGLE;
         wrap_ff     <= 1'b0;
         len_ff      <= '0;
         restart_ff  <= 1'b0;
         rebuilt_ff  <= 1'b0;
         replay_ff   <= 1'b0;
         d_act_ff    <= 1'b0;
         d_addr_ff   <= '0;
         wdata_ff    <= '0;
         rd_valid_ff <= 1'b0;
         rd_data_ff  <= '0;
         done_ff     <= 1'b0;
         err_ff      <= 1'b0;
      end
      else
      begin
         st_ff       <= nxt_st;
         grant_ff    <= nxt_grant;
         a_addr_ff   <= nxt_a_addr;
         a_trans_ff  <= nxt_a_trans;
         a_cnt_ff    <= nxt_a_cnt;
         write_ff    <= nxt_write;
         size_ff     <= nxt_size;
         burst_ff    <= nxt_burst;
         wrap_ff     <= nxt_wrap;
         len_ff      <= nxt_len;
         restart_ff  <= nxt_restart;
         rebuilt_ff  <= nxt_rebuilt;
         replay_ff   <= nxt_replay;
         d_act_ff    <= nxt_d_act;
         d_addr_ff   <= nxt_d_addr;
         wdata_ff    <= nxt_wdata;
         rd_valid_ff <= nxt_rd_valid;
         rd_data_ff  <= nxt_rd_data;
         done_ff     <= nxt_done;
         err_ff      <= nxt_err;
      end
   end
endmodule // bus_master

// ==== src/bus_slave.sv ====
// slave end: address decode, wait states, responses, word store
`timescale 1ns/1ps
module bus_slave (
   input  wire logic                           sys_clk,
   input  wire logic                           srst,
   bus_if.slave                                bus,
   input  wire logic [xfer_pkg::WAIT_W-1:0]    wait_cycles,
   input  wire logic                           fail_req,
   input  wire logic                           retry_req,
   output logic                                xfer_done
);
   typedef enum logic [1:0] {
      SL_IDLE = 2'b00,
      SL_DATA = 2'b01,
      SL_RSP2 = 2'b10
   } slv_state_t;

   localparam int AW = xfer_pkg::ADDR_W;
   localparam int DW = xfer_pkg::DATA_W;
   localparam int MW = xfer_pkg::MEM_AW;

   slv_state_t                    st_ff, nxt_st;
   logic [xfer_pkg::WAIT_W-1:0]   cnt_ff, nxt_cnt;
   logic [AW-1:0]                 addr_ff, nxt_addr;
   logic                          wr_ff, nxt_wr;
   logic [2:0]                    size_ff, nxt_size;
   logic [1:0]                    rsp_ff, nxt_rsp;
   logic [DW-1:0]                 rdata_ff, nxt_rdata;
   logic                          done_ff, nxt_done;
   logic [DW-1:0]                 mem_ff [xfer_pkg::MEM_WORDS];
   logic                          take;
   logic                          sel;
   logic                          finish;
   logic                          mem_we;
   logic [3:0]                    lanes;
   logic [DW-1:0]                 merged;

   // decode: only the low window belongs here, the rest gets error
   assign sel = (bus.haddr[AW-1:MW+2] == '0);

   // ready and response are decoded from state so they settle each cycle
   always_comb
   begin
      bus.hready = 1'b1;
      bus.hresp  = xfer_pkg::RSP_OKAY;
      if (st_ff == SL_DATA)
      begin
         bus.hready = (cnt_ff == '0) & (rsp_ff == xfer_pkg::RSP_OKAY);
         bus.hresp  = (cnt_ff == '0) ? rsp_ff : xfer_pkg::RSP_OKAY;
      end
      else if (st_ff == SL_RSP2)
         bus.hresp = rsp_ff;
   end

   assign bus.hrdata = rdata_ff;
   assign xfer_done  = done_ff;
   // only real types are captured, and only while the address phase ends
   assign take   = bus.hready & bus.htrans[1];
   assign finish = (st_ff == SL_DATA) & (cnt_ff == '0)
                 & (rsp_ff == xfer_pkg::RSP_OKAY);
   assign mem_we = finish & wr_ff;

   // byte lanes written for the captured size and offset
   always_comb
   begin
      case (size_ff)
         xfer_pkg::SZ_BYTE: lanes = 4'h1 << addr_ff[1:0];
         xfer_pkg::SZ_HALF: lanes = addr_ff[1] ? 4'hC : 4'h3;
         default:           lanes = 4'hF;
      endcase
      merged = mem_ff[addr_ff[MW+1:2]];
      for (int i = 0; i < 4; i++)
         if (lanes[i])
            merged[i*8 +: 8] = bus.hwdata[i*8 +: 8];
   end

   always_comb
   begin
      nxt_st    = st_ff;
      nxt_cnt   = cnt_ff;
      nxt_addr  = addr_ff;
      nxt_wr    = wr_ff;
      nxt_size  = size_ff;
      nxt_rsp   = rsp_ff;
      nxt_done  = finish;
      nxt_rdata = '0;
      if (st_ff == SL_DATA && cnt_ff != '0)
         nxt_cnt = cnt_ff - 1'b1;
      else if (st_ff == SL_DATA && rsp_ff != xfer_pkg::RSP_OKAY)
         nxt_st = SL_RSP2;
      else if (take)
      begin
         // next transfer captured in the same cycle the last one ends
         nxt_st   = SL_DATA;
         nxt_addr = bus.haddr;
         nxt_wr   = bus.hwrite;
         nxt_size = bus.hsize;
         nxt_cnt  = wait_cycles;
         nxt_rsp  = (!sel || fail_req) ? xfer_pkg::RSP_ERROR
                  : retry_req ? xfer_pkg::RSP_RETRY : xfer_pkg::RSP_OKAY;
      end
      else if (bus.hready)
         nxt_st = SL_IDLE;
      // read data only in the completing cycle, zero in waits
      if (nxt_st == SL_DATA && nxt_cnt == '0
          && nxt_rsp == xfer_pkg::RSP_OKAY && !nxt_wr)
      begin
         nxt_rdata = mem_ff[nxt_addr[MW+1:2]];
         if (mem_we && nxt_addr[MW+1:2] == addr_ff[MW+1:2])
            nxt_rdata = merged;                                 // forward a same-word write
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         st_ff    <= SL_IDLE;
         cnt_ff   <= '0;
         addr_ff  <= '0;
         wr_ff    <= 1'b0;
         size_ff  <= xfer_pkg::SZ_BYTE;
         rsp_ff   <= xfer_pkg::RSP_OKAY;
         rdata_ff <= '0;
         done_ff  <= 1'b0;
      end
      else
      begin
         st_ff    <= nxt_st;
         cnt_ff   <= nxt_cnt;
         addr_ff  <= nxt_addr;
         wr_ff    <= nxt_wr;
         size_ff  <= nxt_size;
         rsp_ff   <= nxt_rsp;
         rdata_ff <= nxt_rdata;
         done_ff  <= nxt_done;
      end
   end

   // store has no reset; contents are undefined until written
   always_ff @(posedge sys_clk)
   begin
      if (mem_we)
         mem_ff[addr_ff[MW+1:2]] <= merged;
   end
endmodule // bus_slave

// ==== verif/bus_sva.sv ====
// concurrent checks on the shared transfer bus
`timescale 1ns/1ps
module bus_sva (
   input wire logic        sys_clk,
   input wire logic        srst,
   input wire logic        hgrant,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [2:0]  hburst,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [1:0]  hresp
);
   logic [31:0] la_ff, nxt_la, inc, msk, exp_a;
   logic        lw_ff, nxt_lw, own_ff, nxt_own;
   // last captured beat; busy cycles capture nothing, so seq stays relative to it
   always_comb
   begin
      {nxt_la, nxt_lw} = hready && htrans[1] ? {haddr, hwrite} : {la_ff, lw_ff};
      nxt_own = hready ? hgrant : own_ff;   // grant as seen at the last handover edge
      inc = la_ff + (32'h1 << hsize);
      msk = ((32'h1 << hsize) << (hburst[2:1] + 3'h1)) - 32'h1;
      exp_a = hburst[0] || hburst == 3'h0 ? inc : (la_ff & ~msk) | (inc & msk);
   end
   always_ff @(posedge sys_clk)
      {la_ff, lw_ff, own_ff} <= srst ? 34'h0 : {nxt_la, nxt_lw, nxt_own};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   a_addr_held: assert property (!hready && hresp == 2'h0
      |=> $stable({haddr, htrans})) else $error("address moved");
   a_wdata_held: assert property (lw_ff && !hready && hresp == 2'h0
      |=> $stable(hwdata)) else $error("write data moved");
   a_idle_okay: assert property (htrans == 2'h0 && hready
      |=> hready && hresp == 2'h0) else $error("idle answer");
   a_busy_okay: assert property (htrans == 2'h1 && hready
      |=> hready && hresp == 2'h0) else $error("busy answer");
   a_seq_addr: assert property (htrans == 2'h3
      |-> haddr == exp_a && hwrite == lw_ff) else $error("seq beat");
   a_resp_two: assert property (hresp != 2'h0 && !hready
      |=> hready && $stable(hresp)) else $error("response length");
   a_retry_again: assert property (hresp == 2'h2 && !hready
      |-> ##[2:8] htrans == 2'h2 && haddr == la_ff) else $error("no reissue");
   a_grant_first: assert property (htrans != 2'h0
      |-> own_ff) else $error("no grant");
endmodule // bus_sva

// ==== verif/tb_ahb_transfer_protocol.sv ====
// bench joining the master and slave ends
`timescale 1ns/1ps
module tb_ahb_transfer_protocol;
   logic        sys_clk = 1'b0, srst = 1'b1, cmd_valid = 1'b0, arb_hold = 1'b0;
   logic        cmd_write = 1'b0, wr_valid = 1'b0, retry_req = 1'b0;
   logic        fail_req = 1'b0, xfer_done;
   logic [2:0]  cmd_size = 3'h2;
   logic [31:0] cmd_addr = 32'h0, wr_data = 32'h0, rd_data, x, m, mem [16];
   logic [4:0]  cmd_beats = 5'h01;
   logic [2:0]  cmd_burst = 3'h0;
   logic [1:0]  wait_cycles = 2'h0;
   logic        cmd_ready, wr_ready, rd_valid, done, done_err, fin, sq [$];
   logic [31:0] rq [$], wq [$];
   int          failures = 0, num_checks = 0, cyc = 0, k, nb, nx = 0, ne = 0;
   bus_if bus ();
   bus_master bus_master_i (.sys_clk, .srst, .bus, .cmd_valid, .cmd_ready, .cmd_addr,
      .cmd_write, .cmd_size, .cmd_burst, .cmd_beats, .arb_hold, .wr_valid,
      .wr_ready, .wr_data, .rd_valid, .rd_data, .done, .done_err);
   bus_slave bus_slave_i (.sys_clk, .srst, .bus, .wait_cycles, .fail_req,
      .retry_req, .xfer_done);
   bus_sva bus_sva_i (.sys_clk, .srst, .hgrant(bus.hgrant), .haddr(bus.haddr),
      .htrans(bus.htrans), .hwrite(bus.hwrite), .hsize(bus.hsize), .hburst(bus.hburst),
      .hwdata(bus.hwdata), .hready(bus.hready), .hresp(bus.hresp));
   assign fin = done | done_err;
   always #4 sys_clk = ~sys_clk;
   task automatic cmp_rd(logic [31:0] g, e);
      num_checks++;
      if (g !== e)
      begin
         failures++;
         $display("mismatch %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic cmp_st(logic g, e);
      cmp_rd({31'h0, g}, {31'h0, e});
   endtask
   task automatic finish_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wait_hi(ref logic s);
      while (s !== 1'b1)
         @(posedge sys_clk) #1;
   endtask
   // results are matched with the oldest note; negedge avoids the launch race
   always @(negedge sys_clk)
   begin
      if (rd_valid === 1'b1)
         cmp_rd(rd_data, rq.pop_front());
      if (fin === 1'b1)
         cmp_st(done_err, sq.pop_front());
      if (xfer_done === 1'b1)
         nx++;
      cyc++;
      if (cyc == 6000)
      begin
         failures++;
         finish_test();
      end
   end
   // note expected results, issue one command, feed its words with random gaps
   task automatic cmd(logic [31:0] a, logic w, logic [2:0] b, logic [4:0] n, logic e);
      nb = b == 3'h0 ? 1 : b == 3'h1 ? int'(n) : 2 << b[2:1];
      m = 32'((nb << cmd_size) - 1);
      x = a;
      k = wq.size();
      for (int i = 0; i < nb && !e; i++)
      begin
         if (i >= k)
            wq.push_back($urandom);
         if (w)
         begin
            for (int l = 0; l < 4; l++)
               if ((l >> cmd_size) == (x[1:0] >> cmd_size))
                  mem[x[5:2]][l*8 +: 8] = wq[i][l*8 +: 8];
         end
         else
            rq.push_back(mem[x[5:2]]);
         x = b[0] || b == 3'h0 ? x + (32'h1 << cmd_size)
                               : (x & ~m) | ((x + (32'h1 << cmd_size)) & m);
      end
      sq.push_back(e);
      ne += e ? 0 : nb;
      @(posedge sys_clk) #1;
      {cmd_valid, cmd_addr, cmd_write, cmd_burst, cmd_beats} = {1'b1, a, w, b, n};
      fork
         for (int j = k; j < wq.size() && w; j++)
         begin
            wr_data = wq[j];
            wr_valid = 1'b1;
            wait_hi(wr_ready);
            @(posedge sys_clk) #1;
            // valid drops after the last word, or it would be pushed again
            if ($urandom_range(1) || j == wq.size() - 1)
            begin
               wr_valid = 1'b0;
               @(posedge sys_clk) #1;
            end
         end
         begin
            wait_hi(cmd_ready);
            @(posedge sys_clk) #1;
            cmd_valid = 1'b0;
            wait_hi(fin);
         end
      join
      wr_valid = 1'b0;
      wq.delete();
   endtask
   initial
   begin
      void'($urandom(32'hE247C0A8));
      repeat (10) @(posedge sys_clk);
      #1 srst = 1'b0;
      // every burst kind written, then read back, random slave waits
      for (int i = 0; i < 16; i++)
      begin
         wait_cycles = 2'($urandom);
         cmd(i[0] ? 32'h0 : 32'h34, !i[3], i[2:0], 5'h03, 1'b0);
      end
      $display("test bursts done");
      // fill the buffer until it refuses, then drain it in one burst
      k = 0;
      while (wr_ready === 1'b1)
      begin
         wq.push_back($urandom);
         wr_data = wq[k++];
         wr_valid = 1'b1;
         @(posedge sys_clk) #1;
      end
      wr_valid = 1'b0;
      cmp_rd(32'(k), 32'(xfer_pkg::FIFO_DEPTH));
      cmd(32'h10, 1'b1, 3'h5, 5'h00, 1'b0);
      cmd(32'h10, 1'b0, 3'h5, 5'h00, 1'b0);
      $display("test buffer done");
      // halfword wrap and byte steps land in their own lanes, then read words
      cmd_size = 3'h1;
      cmd(32'h22, 1'b1, 3'h2, 5'h00, 1'b0);
      cmd_size = 3'h0;
      cmd(32'h15, 1'b1, 3'h1, 5'h04, 1'b0);
      cmd_size = 3'h2;
      cmd(32'h10, 1'b0, 3'h5, 5'h00, 1'b0);
      $display("test sizes done");
      retry_req = 1'b1;
      fork
         cmd(32'h8, 1'b0, 3'h0, 5'h01, 1'b0);
         #64 retry_req = 1'b0;
      join
      cmd(32'h40, 1'b0, 3'h0, 5'h01, 1'b1);
      // a refused first beat must cancel the rest of the burst
      fail_req = 1'b1;
      cmd(32'h0, 1'b0, 3'h3, 5'h00, 1'b1);
      fail_req = 1'b0;
      fork
         cmd(32'h0, 1'b0, 3'h7, 5'h00, 1'b0);
         #88 arb_hold = 1'b1;
         #112 arb_hold = 1'b0;
      join
      // every completed beat leaves one slave completion pulse
      @(posedge sys_clk) #1;
      cmp_rd(32'(nx), 32'(ne));
      $display("test faults done");
      finish_test();
   end
endmodule // tb_ahb_transfer_protocol
